// ===== verilog/indirect_pkg.sv
// package: address map, field layout and carrier types for the indirect access block
package indirect_pkg;
    localparam int ADDR_W   = 11;
    localparam int OFFS_W   = 8;
    localparam int SECT_W   = 3;
    localparam int DATA_W   = 8;
    localparam int MEM_DEPTH = 2048;

    // special register offsets within sector 0
    localparam logic [7:0] OFF_INDIRECT_PORT_0 = 8'h00;
    localparam logic [7:0] OFF_POINTER_0       = 8'h01;
    localparam logic [7:0] OFF_INDIRECT_PORT_1 = 8'h02;
    localparam logic [7:0] OFF_POINTER_1_LOW   = 8'h03;
    localparam logic [7:0] OFF_POINTER_1_HIGH  = 8'h04;
    localparam logic [7:0] OFF_INDIRECT_PORT_2 = 8'h0C;
    localparam logic [7:0] OFF_POINTER_2_LOW   = 8'h0D;
    localparam logic [7:0] OFF_POINTER_2_HIGH  = 8'h0E;

    localparam logic [2:0] SECTOR_ZERO = 3'h0;
    localparam logic [7:0] READ_ZERO   = 8'h00;
    localparam logic [7:0] PTR_RESET   = 8'h00;

    // one access from the datapath
    typedef struct packed {
        logic               rd;
        logic               wr;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
    } access_type;

    // one access as it reaches the array
    typedef struct packed {
        logic               rd;
        logic               wr;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  wdata;
    } mem_req_type;

    typedef enum logic [1:0] {
        PORT_NONE,
        PORT_0,
        PORT_1,
        PORT_2
    } port_sel_type;
endpackage

// ===== verilog/port_decode.sv
// address decoder: recognises the three indirect port locations in sector 0
`timescale 1ns/100ps
`default_nettype none
module port_decode (
    // address to classify
    input  wire logic [indirect_pkg::ADDR_W-1:0] addr,
    // result
    output var indirect_pkg::port_sel_type       sel
);
    logic [indirect_pkg::SECT_W-1:0] sector;
    logic [indirect_pkg::OFFS_W-1:0] offs;

    always_comb begin
        sector = addr[indirect_pkg::ADDR_W-1:indirect_pkg::OFFS_W];
        offs   = addr[indirect_pkg::OFFS_W-1:0];
        sel    = indirect_pkg::PORT_NONE;
        if (sector == indirect_pkg::SECTOR_ZERO) begin
            case (offs)
                indirect_pkg::OFF_INDIRECT_PORT_0: sel = indirect_pkg::PORT_0;
                indirect_pkg::OFF_INDIRECT_PORT_1: sel = indirect_pkg::PORT_1;
                indirect_pkg::OFF_INDIRECT_PORT_2: sel = indirect_pkg::PORT_2;
                default:                           sel = indirect_pkg::PORT_NONE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== verilog/data_ram.sv
// data memory array: all sectors, registered read, one access per cycle
`timescale 1ns/100ps
`default_nettype none
module data_ram (
    // clock
    input  wire logic                              sys_clk,
    // access
    input  wire indirect_pkg::mem_req_type         req,
    // read data, valid the cycle after a read
    output logic [indirect_pkg::DATA_W-1:0]        rdata_q
);
    // no reset on the array: ordinary ram contents are undefined after reset
    logic [indirect_pkg::DATA_W-1:0] mem [indirect_pkg::MEM_DEPTH];
    logic [indirect_pkg::DATA_W-1:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (req.rd) begin
            rdata_d = mem[req.addr];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
        end
        rdata_q <= rdata_d;
    end
endmodule
`default_nettype wire

// ===== verilog/indirect_access.sv
// indirect access unit: port windows, memory pointers and redirection into data memory
`timescale 1ns/100ps
`default_nettype none
module indirect_access (
    // clock and reset
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    // datapath access
    input  wire indirect_pkg::access_type            acc,
    // read answer, one cycle after the read
    output logic [indirect_pkg::DATA_W-1:0]          rdata_q,
    output logic                                     rvalid_q,
    // pointer view
    output logic [indirect_pkg::DATA_W-1:0]          pointer_0_q,
    output logic [indirect_pkg::DATA_W-1:0]          pointer_1_low_q,
    output logic [indirect_pkg::DATA_W-1:0]          pointer_1_high_q,
    output logic [indirect_pkg::DATA_W-1:0]          pointer_2_low_q,
    output logic [indirect_pkg::DATA_W-1:0]          pointer_2_high_q
);
    // ****************************************************
    // pointer registers
    // ****************************************************
    logic [indirect_pkg::DATA_W-1:0] pointer_0_d;
    logic [indirect_pkg::DATA_W-1:0] pointer_1_low_d;
    logic [indirect_pkg::DATA_W-1:0] pointer_1_high_d;
    logic [indirect_pkg::DATA_W-1:0] pointer_2_low_d;
    logic [indirect_pkg::DATA_W-1:0] pointer_2_high_d;

    // ****************************************************
    // address resolution
    // ****************************************************
    indirect_pkg::port_sel_type        direct_sel;
    indirect_pkg::port_sel_type        target_sel;
    logic [indirect_pkg::ADDR_W-1:0]   eff_addr;
    logic                              indirect;
    logic                              null_hit;
    logic                              ptr_hit;
    logic [indirect_pkg::DATA_W-1:0]   ptr_rdata;
    indirect_pkg::mem_req_type         mem_req;
    logic [indirect_pkg::DATA_W-1:0]   ram_rdata;

    port_decode u_direct_decode (
        .addr (acc.addr),
        .sel  (direct_sel)
    );

    // pointer value is the one held as the access starts
    always_comb begin
        indirect = 1'b1;
        eff_addr = acc.addr;
        case (direct_sel)
            indirect_pkg::PORT_0: begin
                eff_addr = {indirect_pkg::SECTOR_ZERO, pointer_0_q};
            end
            indirect_pkg::PORT_1: begin
                eff_addr = {pointer_1_high_q[indirect_pkg::SECT_W-1:0], pointer_1_low_q};
            end
            indirect_pkg::PORT_2: begin
                eff_addr = {pointer_2_high_q[indirect_pkg::SECT_W-1:0], pointer_2_low_q};
            end
            default: begin
                indirect = 1'b0;
            end
        endcase
    end

    port_decode u_target_decode (
        .addr (eff_addr),
        .sel  (target_sel)
    );

    // a pointer aimed back at a port window hits nothing
    assign null_hit = indirect && (target_sel != indirect_pkg::PORT_NONE);

    // pointers are reached directly or through another pointer alike
    always_comb begin
        ptr_hit   = 1'b1;
        ptr_rdata = indirect_pkg::READ_ZERO;
        if (eff_addr[indirect_pkg::ADDR_W-1:indirect_pkg::OFFS_W] != indirect_pkg::SECTOR_ZERO) begin
            ptr_hit = 1'b0;
        end else begin
            case (eff_addr[indirect_pkg::OFFS_W-1:0])
                indirect_pkg::OFF_POINTER_0:      ptr_rdata = pointer_0_q;
                indirect_pkg::OFF_POINTER_1_LOW:  ptr_rdata = pointer_1_low_q;
                indirect_pkg::OFF_POINTER_1_HIGH: ptr_rdata = pointer_1_high_q;
                indirect_pkg::OFF_POINTER_2_LOW:  ptr_rdata = pointer_2_low_q;
                indirect_pkg::OFF_POINTER_2_HIGH: ptr_rdata = pointer_2_high_q;
                default:                          ptr_hit   = 1'b0;
            endcase
        end
    end

    // ****************************************************
    // pointer update
    // ****************************************************
    always_comb begin
        pointer_0_d      = pointer_0_q;
        pointer_1_low_d  = pointer_1_low_q;
        pointer_1_high_d = pointer_1_high_q;
        pointer_2_low_d  = pointer_2_low_q;
        pointer_2_high_d = pointer_2_high_q;
        if (acc.wr && ptr_hit && !null_hit) begin
            case (eff_addr[indirect_pkg::OFFS_W-1:0])
                indirect_pkg::OFF_POINTER_0:      pointer_0_d      = acc.wdata;
                indirect_pkg::OFF_POINTER_1_LOW:  pointer_1_low_d  = acc.wdata;
                indirect_pkg::OFF_POINTER_1_HIGH: pointer_1_high_d = acc.wdata;
                indirect_pkg::OFF_POINTER_2_LOW:  pointer_2_low_d  = acc.wdata;
                indirect_pkg::OFF_POINTER_2_HIGH: pointer_2_high_d = acc.wdata;
                default:                          pointer_0_d      = pointer_0_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pointer_0_q      <= indirect_pkg::PTR_RESET;
            pointer_1_low_q  <= indirect_pkg::PTR_RESET;
            pointer_1_high_q <= indirect_pkg::PTR_RESET;
            pointer_2_low_q  <= indirect_pkg::PTR_RESET;
            pointer_2_high_q <= indirect_pkg::PTR_RESET;
        end else begin
            pointer_0_q      <= pointer_0_d;
            pointer_1_low_q  <= pointer_1_low_d;
            pointer_1_high_q <= pointer_1_high_d;
            pointer_2_low_q  <= pointer_2_low_d;
            pointer_2_high_q <= pointer_2_high_d;
        end
    end

    // ****************************************************
    // data memory
    // ****************************************************
    // port windows and pointer bytes never reach the array
    always_comb begin
        mem_req.addr  = eff_addr;
        mem_req.wdata = acc.wdata;
        mem_req.rd    = acc.rd && !null_hit && !ptr_hit;
        mem_req.wr    = acc.wr && !null_hit && !ptr_hit && (direct_sel == indirect_pkg::PORT_NONE || indirect);
    end

    data_ram u_ram (
        .sys_clk (sys_clk),
        .req     (mem_req),
        .rdata_q (ram_rdata)
    );

    // ****************************************************
    // read answer
    // ****************************************************
    typedef enum logic [1:0] {
        SRC_RAM,
        SRC_PTR,
        SRC_ZERO
    } src_type;

    src_type                          src_q;
    src_type                          src_d;
    logic [indirect_pkg::DATA_W-1:0]  ptr_hold_q;
    logic [indirect_pkg::DATA_W-1:0]  ptr_hold_d;
    logic                             rvalid_d;
    logic [indirect_pkg::DATA_W-1:0]  rdata_d;

    always_comb begin
        rvalid_d   = acc.rd;
        ptr_hold_d = ptr_rdata;
        src_d      = SRC_RAM;
        if (null_hit) begin
            src_d = SRC_ZERO;
        end else if (ptr_hit) begin
            src_d = SRC_PTR;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            src_q      <= SRC_ZERO;
            ptr_hold_q <= indirect_pkg::READ_ZERO;
            rvalid_q   <= 1'b0;
        end else begin
            src_q      <= src_d;
            ptr_hold_q <= ptr_hold_d;
            rvalid_q   <= rvalid_d;
        end
    end

    // memory read data is already a flop; the mux follows it combinationally
    always_comb begin
        case (src_q)
            SRC_RAM:  rdata_d = ram_rdata;
            SRC_PTR:  rdata_d = ptr_hold_q;
            SRC_ZERO: rdata_d = indirect_pkg::READ_ZERO;
            default:  rdata_d = indirect_pkg::READ_ZERO;
        endcase
    end

    assign rdata_q = rdata_d;
endmodule
`default_nettype wire

// ===== testbench/indirect_access_sva.sv
// checker: port-level properties of the indirect access unit
`timescale 1ns/100ps
`default_nettype none
module indirect_access_sva (
    // clock and reset
    input wire logic                     sys_clk,
    input wire logic                     resetn,
    // access and answer
    input wire indirect_pkg::access_type acc,
    input wire logic [7:0]               rdata_q,
    input wire logic                     rvalid_q,
    // pointers
    input wire logic [7:0]               pointer_0_q,
    input wire logic [7:0]               pointer_1_low_q,
    input wire logic [7:0]               pointer_1_high_q,
    input wire logic [7:0]               pointer_2_low_q,
    input wire logic [7:0]               pointer_2_high_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_rvalid; acc.rd |=> rvalid_q; endproperty
    a_rvalid: assert property (p_rvalid) else $error("no answer after read");
    property p_no_rvalid; !acc.rd |=> !rvalid_q; endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");
    property p_ptr0; acc.wr && acc.addr == 11'h001 |=> pointer_0_q == $past(acc.wdata); endproperty
    a_ptr0: assert property (p_ptr0) else $error("pointer 0 not written");
    property p_ptr1h; acc.wr && acc.addr == 11'h004 |=> pointer_1_high_q == $past(acc.wdata); endproperty
    a_ptr1h: assert property (p_ptr1h) else $error("pointer 1 high not written");
    property p_ptr2l; acc.wr && acc.addr == 11'h00D |=> pointer_2_low_q == $past(acc.wdata); endproperty
    a_ptr2l: assert property (p_ptr2l) else $error("pointer 2 low not written");
    property p_self_rd;
        acc.rd && acc.addr == 11'h000 && pointer_0_q inside {8'h00, 8'h02, 8'h0C} |=> rdata_q == 8'h00;
    endproperty
    a_self_rd: assert property (p_self_rd) else $error("window read not zero");
    property p_self_wr;
        acc.wr && acc.addr == 11'h000 && pointer_0_q inside {8'h00, 8'h02, 8'h0C}
        |=> $stable({pointer_0_q, pointer_1_low_q, pointer_1_high_q, pointer_2_low_q, pointer_2_high_q});
    endproperty
    a_self_wr: assert property (p_self_wr) else $error("window write had effect");
    property p_via0; acc.rd && acc.addr == 11'h000 && pointer_0_q == 8'h01 |=> rdata_q == $past(pointer_0_q);
    endproperty
    a_via0: assert property (p_via0) else $error("port 0 missed target");
    property p_via1;
        acc.rd && acc.addr == 11'h002 && {pointer_1_high_q[2:0], pointer_1_low_q} == 11'h003
        |=> rdata_q == $past(pointer_1_low_q);
    endproperty
    a_via1: assert property (p_via1) else $error("port 1 missed target");
endmodule
bind indirect_access indirect_access_sva u_indirect_access_sva (.sys_clk(sys_clk), .resetn(resetn), .acc(acc),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .pointer_0_q(pointer_0_q), .pointer_1_low_q(pointer_1_low_q),
    .pointer_1_high_q(pointer_1_high_q), .pointer_2_low_q(pointer_2_low_q), .pointer_2_high_q(pointer_2_high_q));
`default_nettype wire

// ===== testbench/cpu_model.sv
// partner model: datapath issuing accesses to the unit
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
    // clock
    input  wire logic                    sys_clk,
    // access and answer
    output var indirect_pkg::access_type acc,
    input  wire logic [7:0]              rdata_q,
    input  wire logic                    rvalid_q
);
    initial acc = '0;
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge sys_clk) acc <= '{1'b0, 1'b1, a, d};
        // idle bus shows inverted values, never stale ones
        @(posedge sys_clk) acc <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // second read issued on the edge that takes the first
    task automatic rd2(input logic [10:0] a, b, output logic [7:0] da, db, output logic va, vb);
        @(posedge sys_clk) acc <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge sys_clk) acc <= '{1'b1, 1'b0, b, 8'h00};
        @(negedge sys_clk) da = rdata_q;
        va = rvalid_q;
        @(posedge sys_clk) acc <= '{1'b0, 1'b0, ~b, 8'hFF};
        @(negedge sys_clk) db = rdata_q;
        vb = rvalid_q;
    endtask
endmodule
`default_nettype wire

// ===== testbench/indirect_access_tb.sv
// testbench: self-checking scenarios for the indirect access unit
`timescale 1ns/100ps
`default_nettype none
module indirect_access_tb;
    logic                     sys_clk;
    logic                     resetn;
    indirect_pkg::access_type acc;
    logic [7:0]               rdata_q, p0, p1l, p1h, p2l, p2h, da, db;
    logic                     rvalid_q, va, vb;
    int                       num_errors = 0;
    int                       checks = 0;

    indirect_access u_indirect_access (.sys_clk(sys_clk), .resetn(resetn), .acc(acc), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .pointer_0_q(p0), .pointer_1_low_q(p1l), .pointer_1_high_q(p1h),
        .pointer_2_low_q(p2l), .pointer_2_high_q(p2h));
    cpu_model u_cpu_model (.sys_clk(sys_clk), .acc(acc), .rdata_q(rdata_q), .rvalid_q(rvalid_q));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [7:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        u_cpu_model.rd2(a, a, da, d, va, vb);
        chk({6'h00, va, vb}, 8'h03);
    endtask
    task automatic scan(input logic [10:0] port, lo);
        for (int s = 0; s < 8; s++) begin
            u_cpu_model.wr(lo + 11'h001, 8'(s));
            u_cpu_model.wr(lo, 8'hF0);
            u_cpu_model.wr(port, 8'h5A ^ 8'(s));
            rd({3'(s), 8'hF0}, da);
            chk(da, 8'h5A ^ 8'(s));
        end
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_pointers;
        logic [10:0] a[5] = '{11'h001, 11'h003, 11'h004, 11'h00D, 11'h00E};
        foreach (a[i]) u_cpu_model.wr(a[i], 8'hA0 + 8'(i));
        foreach (a[i]) begin
            rd(a[i], db);
            chk(db, 8'hA0 + 8'(i));
        end
        chk(p2h, 8'hA4);
    endtask
    task automatic t_port0;
        u_cpu_model.wr(11'h001, 8'h40);
        u_cpu_model.wr(11'h000, 8'hAA);
        u_cpu_model.wr(11'h140, 8'h55);
        rd(11'h040, db);
        chk(db, 8'hAA);
        rd(11'h000, db);
        chk(db, 8'hAA);
        u_cpu_model.wr(11'h001, 8'h01);
        rd(11'h000, db);
        chk(db, 8'h01);
    endtask
    task automatic t_self;
        u_cpu_model.wr(11'h001, 8'h02);
        u_cpu_model.wr(11'h000, 8'h77);
        chk(p0, 8'h02);
        rd(11'h000, db);
        chk(db, 8'h00);
        u_cpu_model.wr(11'h004, 8'h00);
        u_cpu_model.wr(11'h003, 8'h0C);
        u_cpu_model.wr(11'h002, 8'h33);
        chk(p1l, 8'h0C);
        rd(11'h002, db);
        chk(db, 8'h00);
        u_cpu_model.wr(11'h003, 8'h03);
        rd(11'h002, db);
        chk(db, 8'h03);
    endtask
    task automatic t_b2b;
        u_cpu_model.wr(11'h750, 8'h11);
        u_cpu_model.wr(11'h751, 8'h22);
        u_cpu_model.rd2(11'h750, 11'h751, da, db, va, vb);
        chk({da[3:0], db[3:0]}, 8'h12);
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk(p0 | p1l | p1h | p2l | p2h, 8'h00);
        t_pointers();
        t_port0();
        scan(11'h002, 11'h003);
        scan(11'h00C, 11'h00D);
        t_self();
        t_b2b();
        final_report();
    end
    // whole run is a few hundred cycles
    initial begin
        #50us;
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
